// ==== adcsq_pkg.sv ====
// Shared constants, types and register map of the conversion sequencer
package adcsq_pkg;
    // Control register image
    typedef struct packed {
        logic [1:0] clk_sel;
        logic [2:0] chan;
        logic go;
        logic rsv;
        logic en;
    } adcsq_ctrl_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_DELAY = 5'h02,
        ST_CONV = 5'h04,
        ST_ABORT = 5'h08,
        ST_OFF = 5'h10
    } adcsq_state_t;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_RESULT = 8'h04;
    localparam logic [7:0] ADDR_PINCFG = 8'h08;
    localparam logic [7:0] ADDR_FLAG = 8'h0C;
    localparam logic [7:0] ADDR_IE = 8'h10;
    localparam logic [7:0] ADDR_PORT = 8'h14;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [2:0] PINCFG_RST = 3'h0;

    // Field positions and codes
    localparam int FLAG_BIT = 6;
    localparam logic [1:0] CLK_SEL_RC = 2'h3;
    localparam logic [3:0] TRIG_CODE = 4'hB;

    // Timing: half bit periods in oscillator periods (pclk is the oscillator)
    localparam int TOSC_NS = 25;
    localparam logic [4:0] HALF_DIV2 = 5'h01;
    localparam logic [4:0] HALF_DIV8 = 5'h04;
    localparam logic [4:0] HALF_DIV32 = 5'h10;
    localparam int INSTR_TOSC = 4;
    localparam int INSTR_NS = INSTR_TOSC * TOSC_NS;
    localparam logic [2:0] INSTR_CYC = 3'((INSTR_NS + TOSC_NS - 1) / TOSC_NS);
    localparam logic [4:0] CONV_HALVES = 5'h13;
    localparam logic [4:0] ABORT_HALVES = 5'h04;
endpackage

// ==== adcsq_top.sv ====
// Conversion sequencer: APB registers, bit clock, SAR sequencing, trigger and sleep
`timescale 1ns/1ps

// How it works
// (RULE1) Software waits the acquisition interval after a channel change before starting.
// (RULE2) A conversion lasts nineteen half bit periods, nine and a half bit periods.
// (RULE3) Bit period is 2, 8 or 32 oscillator periods, or the RC oscillator.
// (RULE4) Software picks a clock whose bit period meets the minimum.
// (RULE5) Port reads return zero on every pin configured analog.
// (RULE6) Channel field and pin directions never gate a conversion.
// (RULE7) Software does not set start in the write that enables the converter.
// (RULE8) Clearing start mid conversion aborts; the result register stays unchanged.
// (RULE9) Result holds last completed value or last software write.
// (RULE10) After an abort wait two bit periods, then acquire and accept starts.
// (RULE11) Conversion in sleep only runs with the RC clock selected.
// (RULE12) With RC clock, conversion starts one instruction cycle after start is set.
// (RULE13) Completion clears start and loads the result.
// (RULE14) Completion in sleep wakes the device when the interrupt is enabled.
// (RULE15) Sleep with non-RC clock aborts and powers down; enable bit stays set.
// (RULE16) Software issues sleep right after the start-setting instruction.
// (RULE17) Reset disables, aborts, restores registers and makes all pins analog.
// (RULE18) Result register content is undefined after power-on.
// (RULE19) Trigger in trigger mode with converter enabled sets start and clears timer.
// (RULE20) Trigger with converter disabled starts nothing but still clears timer.
// (RULE21) Software selects channel and waits acquisition before a trigger.
// (RULE22) Two bit periods pass between a completion and the next acquisition. The code returns to idle at once and can start again next cycle.
// (RULE23) Completion sets the converter interrupt flag; software clears it.
module adcsq_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog front end
    input wire logic rc_half_tick,
    input wire logic cmp_above,
    output logic [7:0] trial_code,
    output logic [2:0] channel_select_field,
    output logic sample_hold,
    output logic converter_powered,
    output logic [7:0] analog_mask,
    // Port pins
    input wire logic [7:0] port_pins,
    // System
    input wire logic sleep_active,
    input wire logic compare_trigger,
    input wire logic [3:0] compare_mode_field,
    output logic timer_clear,
    output logic wake_request
);
    adcsq_pkg::adcsq_ctrl_t ctrl_ff, nxt_ctrl;
    adcsq_pkg::adcsq_state_t state_ff, nxt_state;
    logic [2:0] pincfg_ff, nxt_pincfg;
    logic flag_ff, nxt_flag;
    logic ie_ff, nxt_ie;
    logic [4:0] div_ff, nxt_div;
    logic [4:0] half_ff, nxt_half;
    logic [2:0] dly_ff, nxt_dly;
    logic [7:0] sar_ff, nxt_sar;
    logic [31:0] rdata_ff, nxt_rdata;
    logic wake_ff, nxt_wake;
    logic tclr_ff, nxt_tclr;
    logic [7:0] result_ff, nxt_result;
    logic result_we;

    logic wr_en, rd_en, mapped, half_tick, is_rc, trig_hit, sleep_off;
    logic [4:0] half_len;
    logic [2:0] bit_idx;

    // Analog pin set per configuration; order RA0 RA1 RA2 RA3 RA5 RE0 RE1 RE2.
    // A reference pin is counted as analog since its digital buffer is off.
    function automatic logic [7:0] cfg_mask(input logic [2:0] cfg);
        logic [7:0] m;
        m = 8'h00;
        case (cfg)
            3'h0, 3'h1: m = 8'hFF;
            3'h2, 3'h3: m = 8'h1F;
            3'h4, 3'h5: m = 8'h0B;
            default: m = 8'h00;
        endcase
        return m;
    endfunction

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign mapped = (paddr == adcsq_pkg::ADDR_CTRL) || (paddr == adcsq_pkg::ADDR_RESULT)
        || (paddr == adcsq_pkg::ADDR_PINCFG) || (paddr == adcsq_pkg::ADDR_FLAG)
        || (paddr == adcsq_pkg::ADDR_IE) || (paddr == adcsq_pkg::ADDR_PORT);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = rdata_ff;

    assign is_rc = (ctrl_ff.clk_sel == adcsq_pkg::CLK_SEL_RC);
    assign sleep_off = sleep_active && !is_rc; // RULE11 RULE15
    assign trig_hit = compare_trigger && (compare_mode_field == adcsq_pkg::TRIG_CODE);

    // Half bit period tick
    always_comb begin
        case (ctrl_ff.clk_sel)
            2'h0: half_len = adcsq_pkg::HALF_DIV2;
            2'h1: half_len = adcsq_pkg::HALF_DIV8;
            default: half_len = adcsq_pkg::HALF_DIV32;
        endcase
    end
    assign half_tick = is_rc ? rc_half_tick : (div_ff == half_len - 5'h01); // RULE3
    assign bit_idx = 3'h7 - half_ff[3:1];

    assign analog_mask = cfg_mask(pincfg_ff); // RULE17
    assign channel_select_field = ctrl_ff.chan;
    assign trial_code = sar_ff;
    // Sample and hold output is asserted only in ST_CONV, so it stays low
    // through the post-abort wait and while idle
    assign sample_hold = (state_ff == adcsq_pkg::ST_CONV); // RULE10
    assign converter_powered = ctrl_ff.en && !sleep_off; // RULE15
    assign wake_request = wake_ff;
    assign timer_clear = tclr_ff;

    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_state = state_ff;
        nxt_pincfg = pincfg_ff;
        nxt_flag = flag_ff;
        nxt_ie = ie_ff;
        nxt_div = 5'h00;
        nxt_half = half_ff;
        nxt_dly = dly_ff;
        nxt_sar = sar_ff;
        nxt_rdata = rdata_ff;
        nxt_wake = 1'b0;
        nxt_tclr = trig_hit; // RULE20
        nxt_result = result_ff;
        result_we = 1'b0;

        if (state_ff != adcsq_pkg::ST_IDLE && !is_rc && !half_tick) begin
            nxt_div = div_ff + 5'h01;
        end

        // Register reads are latched in the setup phase
        if (rd_en) begin
            nxt_rdata = 32'h0000_0000;
            if (paddr == adcsq_pkg::ADDR_CTRL) begin
                nxt_rdata[7:0] = ctrl_ff;
            end else if (paddr == adcsq_pkg::ADDR_RESULT) begin
                nxt_rdata[7:0] = result_ff;
            end else if (paddr == adcsq_pkg::ADDR_PINCFG) begin
                nxt_rdata[2:0] = pincfg_ff;
            end else if (paddr == adcsq_pkg::ADDR_FLAG) begin
                nxt_rdata[adcsq_pkg::FLAG_BIT] = flag_ff;
            end else if (paddr == adcsq_pkg::ADDR_IE) begin
                nxt_rdata[adcsq_pkg::FLAG_BIT] = ie_ff;
            end else if (paddr == adcsq_pkg::ADDR_PORT) begin
                nxt_rdata[7:0] = port_pins & ~analog_mask; // RULE5
            end
        end

        if (wr_en) begin
            if (paddr == adcsq_pkg::ADDR_CTRL) begin
                nxt_ctrl = pwdata[7:0];
                nxt_ctrl.rsv = 1'b0;
                // Start only takes effect on an already enabled converter
                nxt_ctrl.go = pwdata[2] && ctrl_ff.en && pwdata[0]; // RULE7
            end else if (paddr == adcsq_pkg::ADDR_RESULT) begin
                nxt_result = pwdata[7:0]; // RULE9
                result_we = 1'b1;
            end else if (paddr == adcsq_pkg::ADDR_PINCFG) begin
                nxt_pincfg = pwdata[2:0];
            end else if (paddr == adcsq_pkg::ADDR_FLAG) begin
                nxt_flag = pwdata[adcsq_pkg::FLAG_BIT]; // RULE23
            end else if (paddr == adcsq_pkg::ADDR_IE) begin
                nxt_ie = pwdata[adcsq_pkg::FLAG_BIT];
            end
        end

        // Trigger after the bus write so it is never lost to it
        if (trig_hit && nxt_ctrl.en) begin
            nxt_ctrl.go = 1'b1; // RULE19
        end

        case (state_ff)
            adcsq_pkg::ST_IDLE: begin
                // Channel and pin direction are deliberately not consulted
                if (ctrl_ff.go && ctrl_ff.en && !sleep_off) begin // RULE6
                    nxt_half = 5'h00;
                    nxt_sar = 8'h80;
                    nxt_dly = 3'h0;
                    nxt_state = is_rc ? adcsq_pkg::ST_DELAY : adcsq_pkg::ST_CONV; // RULE12
                end
            end
            adcsq_pkg::ST_DELAY: begin
                nxt_dly = dly_ff + 3'h1;
                if (dly_ff == adcsq_pkg::INSTR_CYC - 3'h1) begin
                    nxt_state = adcsq_pkg::ST_CONV; // RULE12
                end
            end
            adcsq_pkg::ST_CONV: begin
                if (half_tick) begin
                    nxt_half = half_ff + 5'h01;
                    if (half_ff[0] && half_ff < 5'h10) begin
                        nxt_sar[bit_idx] = cmp_above;
                        if (bit_idx != 3'h0) begin
                            nxt_sar[bit_idx - 3'h1] = 1'b1;
                        end
                    end
                    // Sleep on an oscillator clock aborts, so a last tick there completes nothing
                    if (half_ff == adcsq_pkg::CONV_HALVES - 5'h01 && !sleep_off) begin // RULE2
                        nxt_ctrl.go = 1'b0; // RULE13
                        nxt_result = sar_ff; // RULE13
                        result_we = 1'b1;
                        nxt_flag = 1'b1; // RULE23
                        nxt_wake = sleep_active && ie_ff; // RULE14
                        nxt_state = adcsq_pkg::ST_IDLE;
                    end
                end
            end
            adcsq_pkg::ST_ABORT: begin
                if (half_tick) begin
                    nxt_half = half_ff + 5'h01;
                    if (half_ff == adcsq_pkg::ABORT_HALVES - 5'h01) begin
                        nxt_state = adcsq_pkg::ST_IDLE; // RULE10
                    end
                end
            end
            adcsq_pkg::ST_OFF: begin
                if (!sleep_off) begin
                    nxt_state = adcsq_pkg::ST_IDLE;
                end
            end
            default: nxt_state = adcsq_pkg::ST_IDLE;
        endcase

        // Abort paths: software clear, disable, or sleep on an oscillator clock
        if (state_ff == adcsq_pkg::ST_DELAY || state_ff == adcsq_pkg::ST_CONV) begin
            if (sleep_off) begin
                nxt_ctrl.go = 1'b0;
                nxt_state = adcsq_pkg::ST_OFF; // RULE15
                result_we = 1'b0;
                nxt_result = result_ff;
            end else if (!nxt_ctrl.go || !nxt_ctrl.en) begin
                if (nxt_state != adcsq_pkg::ST_IDLE || result_we == 1'b0) begin
                    nxt_ctrl.go = 1'b0;
                    nxt_half = 5'h00;
                    nxt_div = 5'h00;
                    nxt_state = adcsq_pkg::ST_ABORT; // RULE8
                end
            end
        end
        if (state_ff == adcsq_pkg::ST_IDLE && sleep_off && ctrl_ff.en) begin
            nxt_state = adcsq_pkg::ST_OFF;
        end

        // Hardware set wins over a software clear in the same cycle
        if (flag_ff == 1'b0 && nxt_flag == 1'b0 && state_ff == adcsq_pkg::ST_CONV
            && half_tick && half_ff == adcsq_pkg::CONV_HALVES - 5'h01 && !sleep_off) begin
            nxt_flag = 1'b1; // RULE23
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= adcsq_pkg::CTRL_RST; // RULE17
            state_ff <= adcsq_pkg::ST_IDLE; // RULE17
            pincfg_ff <= adcsq_pkg::PINCFG_RST; // RULE17
            flag_ff <= 1'b0;
            ie_ff <= 1'b0;
            div_ff <= 5'h00;
            half_ff <= 5'h00;
            dly_ff <= 3'h0;
            sar_ff <= 8'h00;
            rdata_ff <= 32'h0000_0000;
            wake_ff <= 1'b0;
            tclr_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            state_ff <= nxt_state;
            pincfg_ff <= nxt_pincfg;
            flag_ff <= nxt_flag;
            ie_ff <= nxt_ie;
            div_ff <= nxt_div;
            half_ff <= nxt_half;
            dly_ff <= nxt_dly;
            sar_ff <= nxt_sar;
            rdata_ff <= nxt_rdata;
            wake_ff <= nxt_wake;
            tclr_ff <= nxt_tclr;
        end
    end

    // No reset: content is unknown until the first conversion or write
    always_ff @(posedge pclk) begin
        result_ff <= nxt_result; // RULE18
    end
endmodule // adcsq_top

// ==== adcsq_afe_model.sv ====
// Analog front end model: comparator on a set level and the RC half ticks
`timescale 1ns/1ps
module adcsq_afe_model #(
    parameter int RC_DIV = 3
) (
    // Clock and power
    input wire logic pclk,
    input wire logic run,
    // Converter side
    input wire logic [7:0] trial_code,
    input wire logic [7:0] level,
    output logic cmp_above,
    output logic rc_half_tick
);
    int cnt = 0;
    initial rc_half_tick = 1'h0;
    assign cmp_above = level >= trial_code;
    // RC oscillator stands still while the converter is unpowered
    always @(posedge pclk) begin
        cnt <= run && cnt < RC_DIV - 1 ? cnt + 1 : 0;
        rc_half_tick <= run && cnt == RC_DIV - 1;
    end
endmodule // adcsq_afe_model

// ==== adcsq_properties.sv ====
// Checker of the conversion sequencer top ports
`timescale 1ns/1ps
module adcsq_properties (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // Converter and pins
    input wire logic sample_hold,
    input wire logic converter_powered,
    input wire logic [7:0] analog_mask,
    input wire logic [7:0] port_pins,
    // System
    input wire logic sleep_active,
    input wire logic compare_trigger,
    input wire logic [3:0] compare_mode_field,
    input wire logic timer_clear,
    input wire logic wake_request
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Shadow of written fields, reset like the design
    logic [1:0] sel_ff, nxt_sel;
    logic en_ff, nxt_en, ie_ff, nxt_ie, wr, rd_port, trig;
    logic [9:0] cnt_ff, nxt_cnt, lim;
    always_comb begin
        wr = psel && penable && pwrite;
        rd_port = psel && !penable && !pwrite && paddr == adcsq_pkg::ADDR_PORT;
        trig = compare_trigger && compare_mode_field == adcsq_pkg::TRIG_CODE;
        nxt_sel = wr && paddr == adcsq_pkg::ADDR_CTRL ? pwdata[7:6] : sel_ff;
        nxt_en = wr && paddr == adcsq_pkg::ADDR_CTRL ? pwdata[0] : en_ff;
        nxt_ie = wr && paddr == adcsq_pkg::ADDR_IE ? pwdata[6] : ie_ff;
        nxt_cnt = sample_hold ? cnt_ff + 10'h001 : 10'h000;
        lim = sel_ff == 2'h0 ? 10'h013 : sel_ff == 2'h1 ? 10'h04C : 10'h130;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_ff <= 2'h0;
            en_ff <= 1'h0;
            ie_ff <= 1'h0;
            cnt_ff <= 10'h000;
        end else begin
            sel_ff <= nxt_sel;
            en_ff <= nxt_en;
            ie_ff <= nxt_ie;
            cnt_ff <= nxt_cnt;
        end
    end
    port_read_a: assert property (rd_port |=>
        prdata == {24'h000000, $past(port_pins) & ~$past(analog_mask)}) else $error("port read");
    reset_pins_a: assert property ($rose(presetn) |->
        analog_mask == 8'hFF && !converter_powered && !sample_hold) else $error("reset state");
    conv_length_a: assert property (sample_hold && sel_ff != adcsq_pkg::CLK_SEL_RC |->
        cnt_ff <= lim) else $error("conversion too long");
    trig_clear_a: assert property (trig |=> timer_clear) else $error("no timer clear");
    clear_cause_a: assert property (timer_clear |-> $past(trig) ##1 !timer_clear)
        else $error("stray timer clear");
    power_gate_a: assert property (converter_powered ==
        (en_ff && !(sleep_active && sel_ff != adcsq_pkg::CLK_SEL_RC))) else $error("power gate");
    sleep_stop_a: assert property (sleep_active && sel_ff != adcsq_pkg::CLK_SEL_RC |->
        ##[1:2] !sample_hold) else $error("runs in sleep");
    wake_gate_a: assert property (wake_request |->
        ie_ff && $past(sleep_active) ##1 !wake_request) else $error("bad wake");
    cover property ($fell(sample_hold));
    cover property (wake_request);
    cover property (timer_clear);
endmodule // adcsq_properties
bind adcsq_top adcsq_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .sample_hold, .converter_powered, .analog_mask, .port_pins,
    .sleep_active, .compare_trigger, .compare_mode_field, .timer_clear, .wake_request);

// ==== adcsq_top_test.sv ====
// Self-checking bench of the conversion sequencer
`timescale 1ns/1ps
module adcsq_top_test;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, er;
    logic sleep_active = 1'h0, compare_trigger = 1'h0;
    logic [7:0] paddr = 8'h00, port_pins = 8'hFF, level = 8'h00, lf = 8'h33, v;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] compare_mode_field = 4'h0;
    logic pready, pslverr, cmp_above, rc_half_tick, sample_hold, converter_powered;
    logic timer_clear, wake_request;
    logic [7:0] trial_code, analog_mask;
    logic [2:0] channel_select_field;
    int error_cnt = 0, compares = 0, cyc = 0, t0;
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;
    adcsq_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rc_half_tick, .cmp_above, .trial_code, .channel_select_field,
        .sample_hold, .converter_powered, .analog_mask, .port_pins, .sleep_active,
        .compare_trigger, .compare_mode_field, .timer_clear, .wake_request);
    adcsq_afe_model AFE (.pclk, .run(converter_powered), .trial_code, .level, .cmp_above,
        .rc_half_tick);
    function automatic logic [7:0] rnd();
        lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
        return lf;
    endfunction
    function automatic logic [7:0] amask(input logic [2:0] c);
        return c < 3'h2 ? 8'hFF : c < 3'h4 ? 8'h1F : c < 3'h6 ? 8'h0B : 8'h00;
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rdr(input logic [7:0] a);
        apb(1'h0, a, 32'h0);
    endtask
    task automatic wctl(input logic [7:0] d);
        apb(1'h1, adcsq_pkg::ADDR_CTRL, {24'h0, d});
    endtask
    task automatic wait_done();
        do rdr(adcsq_pkg::ADDR_CTRL); while (rd[2] !== 1'h0);
    endtask
    task automatic trig(input logic [3:0] m);
        compare_mode_field <= m;
        compare_trigger <= 1'h1;
        @(posedge pclk);
        compare_trigger <= 1'h0;
        rdr(adcsq_pkg::ADDR_CTRL);
    endtask
    task automatic conv(input logic [1:0] s, input logic ab);
        int h;
        h = s == 2'h0 ? 1 : s == 2'h1 ? 4 : 16;
        v = rnd();
        level <= v;
        wctl({s, v[2:0], 3'h1});
        repeat (40) @(posedge pclk);
        chk("channel", {29'h0, v[2:0]}, {29'h0, channel_select_field});
        apb(1'h1, adcsq_pkg::ADDR_RESULT, {24'h0, ~v});
        wctl({s, v[2:0], 3'h5});
        t0 = cyc;
        if (ab) begin
            repeat (8) @(posedge pclk);
            wctl({s, v[2:0], 3'h1});
            rdr(adcsq_pkg::ADDR_RESULT);
            chk("aborted result", {24'h0, ~v}, rd);
            wctl({s, v[2:0], 3'h5});
            t0 = cyc;
        end
        wait_done();
        chk("conv time", 32'h1, cyc - t0 >= 19 * h && cyc - t0 <= 23 * h + 8);
        rdr(adcsq_pkg::ADDR_RESULT);
        chk("result", {24'h0, v}, rd);
        rdr(adcsq_pkg::ADDR_FLAG);
        chk("flag", 32'h1, rd[6]);
        apb(1'h1, adcsq_pkg::ADDR_FLAG, 32'h0);
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        rdr(adcsq_pkg::ADDR_PORT);
        chk("port after reset", 32'h0, rd);
        rdr(8'h18);
        chk("unmapped error", 32'h1, er);
        for (int c = 0; c < 8; c++) begin
            v = rnd();
            port_pins <= v;
            apb(1'h1, adcsq_pkg::ADDR_PINCFG, 32'(c));
            rdr(adcsq_pkg::ADDR_PORT);
            chk("port", {24'h0, v & ~amask(3'(c))}, rd);
        end
        $display("pin test done");
        for (int s = 0; s < 3; s++)
            conv(2'(s), 1'h0);
        conv(2'h2, 1'h1);
        $display("conversion test done");
        for (int m = 0; m < 16; m++) begin
            wctl(8'h01);
            repeat (40) @(posedge pclk);
            trig(4'(m));
            chk("trigger start", 32'(4'(m) == adcsq_pkg::TRIG_CODE), rd[2]);
            wait_done();
        end
        wctl(8'h00);
        trig(adcsq_pkg::TRIG_CODE);
        chk("trigger while off", 32'h0, rd);
        $display("trigger test done");
        apb(1'h1, adcsq_pkg::ADDR_IE, 32'h40);
        v = rnd();
        level <= v;
        wctl(8'hC1);
        repeat (40) @(posedge pclk);
        wctl(8'hC5);
        sleep_active <= 1'h1;
        // Outputs are looked at on the falling edge, where they have settled
        repeat (2) @(negedge pclk);
        chk("rc delay", 32'h0, sample_hold);
        repeat (600) if (wake_request !== 1'h1) @(negedge pclk);
        chk("wake", 32'h1, wake_request);
        @(posedge pclk);
        sleep_active <= 1'h0;
        rdr(adcsq_pkg::ADDR_RESULT);
        chk("sleep result", {24'h0, v}, rd);
        rdr(adcsq_pkg::ADDR_CTRL);
        chk("done in sleep", 32'hC1, rd);
        apb(1'h1, adcsq_pkg::ADDR_IE, 32'h0);
        wctl(8'h81);
        apb(1'h1, adcsq_pkg::ADDR_RESULT, 32'hA5);
        wctl(8'h85);
        repeat (10) @(posedge pclk);
        sleep_active <= 1'h1;
        repeat (2) @(posedge pclk);
        rdr(adcsq_pkg::ADDR_CTRL);
        chk("sleep abort", 32'h81, rd);
        sleep_active <= 1'h0;
        repeat (400) @(posedge pclk);
        rdr(adcsq_pkg::ADDR_RESULT);
        chk("result after sleep", 32'hA5, rd);
        $display("sleep test done");
        wctl(8'h85);
        presetn <= 1'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        rdr(adcsq_pkg::ADDR_CTRL);
        chk("ctrl after reset", 32'h0, rd);
        rdr(adcsq_pkg::ADDR_PINCFG);
        chk("pincfg after reset", 32'h0, rd);
        $display("reset test done");
        finish_test();
    end
    // Watchdog well beyond the few thousand cycles the tests need
    initial begin
        repeat (30000) @(posedge pclk);
        error_cnt++;
        finish_test();
    end
endmodule // adcsq_top_test
